// File: include/rist_regs.vh
`ifndef RIST_REGS_VH
`define RIST_REGS_VH
// Register byte offsets (APB, one word each)
`define RIST_CTRL_OFF 12'h000
`define RIST_PRICE_OFF 12'h004
`define RIST_FINT_OFF 12'h008
`define RIST_FLAG_OFF 12'h00c
`define RIST_FLEFT_OFF 12'h010
`define RIST_COST_OFF 12'h014
`define RIST_STAT_OFF 12'h018
`define RIST_IRQS_OFF 12'h01c
`define RIST_IRQM_OFF 12'h020
`define RIST_ENGY_OFF 12'h024
`define RIST_POWY_OFF 12'h028
// Control register fields
`define RIST_CTRL_STOPEN 0
`define RIST_CTRL_FRKEY 1
`define RIST_CTRL_DRVEN 2
`define RIST_CTRL_EMCLR 3
`define RIST_CTRL_LATCH 4
`define RIST_CTRL_RESET 32'h0000_0004
// Status and interrupt fields
`define RIST_ST_INHIBIT 0
`define RIST_ST_RUN 1
`define RIST_IRQ_FILTER 0
`define RIST_IRQ_STOP 1
`define RIST_IRQ_TRIPRST 2
// Limits
`define RIST_PRICE_MAX 16'd6000
`define RIST_FINT_MAX 16'd30000
// Simultaneous run qualification time
`define RIST_BOTH_MS 60
`define RIST_CLK_KHZ 100000
`define RIST_BOTH_CYC (`RIST_BOTH_MS * `RIST_CLK_KHZ)
`endif

// File: rtl/rist_seq_helper.v
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "rist_regs.vh"
module rist_seq_helper #(
  parameter BOTH_CYC = `RIST_BOTH_CYC
) (
  input wire clk_i, // 100 MHz clock
  input wire rst_i, // Async reset, high
  input wire ce_i, // Clock enable
  // APB slave
  input wire psel_i, // APB select
  input wire penable_i, // APB enable
  input wire pwrite_i, // APB direction
  input wire [11:0] paddr_i, // APB byte address
  input wire [31:0] pwdata_i, // APB write data
  input wire [3:0] pstrb_i, // APB byte strobes
  output wire pready_o, // APB ready
  output reg [31:0] prdata_o, // APB read data
  output wire pslverr_o, // APB error
  // Keypad and run command pins, synchronised
  input wire stop_key_i, // Stop key pin
  input wire run_key_i, // Run key pin
  input wire run_fwd_i, // Run forward bit
  input wire run_rev_i, // Run reverse bit
  input wire run_seq_i, // Run sequencing bit
  // Same-clock bits from the latch logic
  input wire not_stop_i, // Not stop bit
  input wire fwd_latched_i, // Forward after latch
  input wire rev_latched_i, // Reverse after latch
  input wire seq_latched_i, // Run after latch
  // Drive state pins, synchronised
  input wire hardware_enable_i, // Hardware enable pin
  input wire tripped_i, // Drive tripped
  input wire undervoltage_state_i, // Undervoltage state
  input wire keypad_ref_i, // Keypad reference mode
  input wire inverter_active_i, // Inverter active
  input wire run_hour_tick_i, // Run-time hour increment
  // Same-clock data inputs
  input wire [15:0] energy_meter_mwh_i, // Meter MWh from integrator
  input wire [15:0] energy_meter_kwh_i, // Meter kWh from integrator
  input wire [15:0] power_kw_i, // Instantaneous power, kW
  input wire [31:0] powered_years_days_i, // Powered-up years.days
  // Sequencer and parameter outputs
  output reg seq_run_permit_o, // Sequencer run allowed
  output reg trip_reset_o, // Trip reset pulse
  output reg drive_enabled_o, // Combined drive enable
  output reg run_hours_en_o, // Run-time clock advance
  output reg energy_meter_clear_o, // Integrator hold clear
  output reg fwd_rev_key_enable_o, // Fwd/rev key enable
  output reg [15:0] energy_meter_mwh_o, // Shown MWh
  output reg [15:0] energy_meter_kwh_o, // Shown kWh
  output reg [31:0] running_cost_o, // Cost per hour
  output reg filter_change_flag_o, // Filter change due
  output wire irq_o // Interrupt, level
);

  // Two-stage synchronisers for pin inputs
  // Stop key presses and the hour tick act on rising edges after these,
  // so each pin adds two cycles of latency
  reg [15:0] s1_q;
  reg [15:0] s2_q;
  wire [15:0] pin_raw = {5'h00, run_hour_tick_i, inverter_active_i,
    keypad_ref_i, undervoltage_state_i, tripped_i, hardware_enable_i,
    run_key_i, stop_key_i, run_fwd_i, run_rev_i, run_seq_i};
  wire fwd = s2_q[2];
  wire rev = s2_q[1];
  wire seq = s2_q[0];
  wire stop_k = s2_q[3];
  wire run_k = s2_q[4];
  wire hw_en = s2_q[5];
  wire trip = s2_q[6];
  wire uv = s2_q[7];
  wire kref = s2_q[8];
  wire inv_act = s2_q[9];
  wire hr_tick = s2_q[10];

  // Register state
  reg [31:0] ctrl_q;
  reg [15:0] price_q;
  reg [15:0] fint_q;
  reg [15:0] fleft_q;
  reg flag_q;
  reg [2:0] irqs_q;
  reg [2:0] irqm_q;
  reg inhibit_q;
  reg stop_prev_q;
  reg hr_prev_q;
  reg [23:0] both_cnt_q;
  reg both_ok_q;

  wire stop_en = ctrl_q[`RIST_CTRL_STOPEN];
  wire drv_en = ctrl_q[`RIST_CTRL_DRVEN];
  wire emclr = ctrl_q[`RIST_CTRL_EMCLR];
  wire latch_sel = ctrl_q[`RIST_CTRL_LATCH];

  // APB decode
  // Zero wait states: every access ends in its first access cycle
  // Writes are dropped while the clock enable is low
  wire wr_acc = psel_i & penable_i & pwrite_i & ce_i;
  wire rd_acc = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  // Address match, shared by write, read and error decode
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Saturates a written value at its upper limit
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] mx;
    begin
      clamp16 = (v > mx) ? mx : v;
    end
  endfunction

  wire mapped = hit(paddr_i, `RIST_CTRL_OFF) | hit(paddr_i, `RIST_PRICE_OFF) |
    hit(paddr_i, `RIST_FINT_OFF) | hit(paddr_i, `RIST_FLAG_OFF) |
    hit(paddr_i, `RIST_FLEFT_OFF) | hit(paddr_i, `RIST_COST_OFF) |
    hit(paddr_i, `RIST_STAT_OFF) | hit(paddr_i, `RIST_IRQS_OFF) |
    hit(paddr_i, `RIST_IRQM_OFF) | hit(paddr_i, `RIST_ENGY_OFF) |
    hit(paddr_i, `RIST_POWY_OFF);
  assign pslverr_o = psel_i & penable_i & ~mapped;
  wire wr_ok = wr_acc & mapped & pstrb_i[0];

  // Combined enable, needs both parameter and hardware source
  wire disabled = ~drv_en | ~hw_en;
  wire stop_edge = stop_k & ~stop_prev_q;
  wire both = fwd & rev;
  wire all_zero = ~(fwd | rev | seq);
  wire lat_zero = ~(fwd_latched_i | rev_latched_i | seq_latched_i);
  wire exit0 = all_zero | disabled | uv;
  wire exit1 = lat_zero | ~not_stop_i | disabled | uv;
  wire exit_any = (latch_sel ? exit1 : exit0) | both_ok_q;
  // Exit conditions are levels, acted on only while inhibited
  // Run held with Stop, keypad reference only
  wire keep_run = run_k & kref;
  wire withdraw = stop_edge & (stop_en | trip) & ~keep_run;
  wire flag_wr = wr_ok & hit(paddr_i, `RIST_FLAG_OFF);
  wire flag_fall = flag_wr & flag_q & ~pwdata_i[0];
  wire hr_edge = hr_tick & ~hr_prev_q;
  wire filt_evt = hr_edge & inv_act & (fint_q != 16'h0000) &
    (fleft_q == 16'h0001);

  // Synchronisers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
    end else if (ce_i) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  // Simultaneous forward and reverse qualifier
  // The full count must be seen on consecutive cycles, so a
  // single dropout of either bit starts the 60 ms over
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      both_cnt_q <= 24'h000000;
      both_ok_q <= 1'b0;
    end else if (ce_i) begin
      if (!both) begin
        both_cnt_q <= 24'h000000;
        both_ok_q <= 1'b0;
      end else if (both_cnt_q >= BOTH_CYC - 1) begin
        both_ok_q <= 1'b1;
      end else begin
        both_cnt_q <= both_cnt_q + 24'h000001;
      end
    end
  end

  // Stop key edge history and trip reset pulse
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_prev_q <= 1'b0;
      trip_reset_o <= 1'b0;
    end else if (ce_i) begin
      stop_prev_q <= stop_k;
      // Stop edge resets trip, run held keeps running in keypad mode
      trip_reset_o <= stop_edge & trip;
    end
  end

  // Stop key inhibit
  // A withdraw in the same cycle as an exit keeps the inhibit set,
  // but a standing exit clears it again on the next cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inhibit_q <= 1'b0;
      seq_run_permit_o <= 1'b0;
    end else if (ce_i) begin
      if (withdraw)
        inhibit_q <= 1'b1;
      else if (exit_any)
        inhibit_q <= 1'b0;
      // Permit never raised by the stop key itself
      // Controller drives a fresh start after release
      seq_run_permit_o <= ~inhibit_q & ~withdraw & ~disabled;
    end
  end

  // Control and parameter registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `RIST_CTRL_RESET;
      price_q <= 16'h0000;
      fint_q <= 16'h0000;
      irqm_q <= 3'h0;
    end else if (wr_ok) begin
      // Out-of-range price and interval writes saturate at the limit
      if (hit(paddr_i, `RIST_CTRL_OFF))
        ctrl_q <= {27'h0000000, pwdata_i[4:0]};
      else if (hit(paddr_i, `RIST_PRICE_OFF))
        price_q <= clamp16(pwdata_i[15:0], `RIST_PRICE_MAX);
      else if (hit(paddr_i, `RIST_FINT_OFF))
        fint_q <= clamp16(pwdata_i[15:0], `RIST_FINT_MAX);
      else if (hit(paddr_i, `RIST_IRQM_OFF))
        irqm_q <= pwdata_i[2:0];
    end
  end

  // Hour tick edge history
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      hr_prev_q <= 1'b0;
    else if (ce_i)
      hr_prev_q <= hr_tick;
  end

  // Filter countdown and flag
  // The flag sets on the hour that takes time left from one to zero;
  // a software clear in that same cycle loses to the set
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fleft_q <= 16'h0000;
      flag_q <= 1'b0;
    end else if (ce_i) begin
      if (fint_q == 16'h0000) begin
        fleft_q <= 16'h0000;
      end else if (flag_fall) begin
        fleft_q <= fint_q;
      end else if (hr_edge && inv_act && fleft_q != 16'h0000) begin
        fleft_q <= fleft_q - 16'h0001;
      end
      // Flag at zero, set wins over write
      if (filt_evt)
        flag_q <= 1'b1;
      else if (flag_wr)
        flag_q <= pwdata_i[0];
    end
  end

  // Sticky interrupt status, write one clears, set wins
  // Bit 0 filter due, bit 1 stop withdraw, bit 2 trip reset
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irqs_q <= 3'h0;
    end else if (ce_i) begin
      irqs_q <= (irqs_q & ~((wr_ok && hit(paddr_i, `RIST_IRQS_OFF)) ?
        pwdata_i[2:0] : 3'h0)) | {trip_reset_o, withdraw, filt_evt};
    end
  end
  assign irq_o = |(irqs_q & irqm_q);

  // Enable and pass-through control outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_enabled_o <= 1'b0;
      run_hours_en_o <= 1'b0;
      energy_meter_clear_o <= 1'b0;
      fwd_rev_key_enable_o <= 1'b0;
    end else if (ce_i) begin
      drive_enabled_o <= ~disabled;
      // Run hours only while inverter active
      run_hours_en_o <= inv_act;
      energy_meter_clear_o <= emclr;
      fwd_rev_key_enable_o <= ctrl_q[`RIST_CTRL_FRKEY];
    end
  end

  // Energy meter readout, held at zero by the clear bit
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      energy_meter_mwh_o <= 16'h0000;
      energy_meter_kwh_o <= 16'h0000;
    end else if (ce_i) begin
      energy_meter_mwh_o <= emclr ? 16'h0000 : energy_meter_mwh_i;
      energy_meter_kwh_o <= emclr ? 16'h0000 : energy_meter_kwh_i;
    end
  end

  // Running cost and filter flag mirror
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      running_cost_o <= 32'h00000000;
      filter_change_flag_o <= 1'b0;
    end else if (ce_i) begin
      // Cost is price times power, tenths
      running_cost_o <= price_q * power_kw_i;
      filter_change_flag_o <= flag_q;
    end
  end

  // Read mux
  // Data is driven only in the access phase and is zero otherwise,
  // so an idle bus shows no register contents
  always @* begin
    prdata_o = 32'h00000000;
    if (rd_acc) begin
      if (hit(paddr_i, `RIST_CTRL_OFF))
        prdata_o = ctrl_q;
      else if (hit(paddr_i, `RIST_PRICE_OFF))
        prdata_o = {16'h0000, price_q};
      else if (hit(paddr_i, `RIST_FINT_OFF))
        prdata_o = {16'h0000, fint_q};
      else if (hit(paddr_i, `RIST_FLAG_OFF))
        prdata_o = {31'h00000000, flag_q};
      else if (hit(paddr_i, `RIST_FLEFT_OFF))
        prdata_o = {16'h0000, fleft_q};
      else if (hit(paddr_i, `RIST_COST_OFF))
        prdata_o = running_cost_o;
      else if (hit(paddr_i, `RIST_STAT_OFF))
        prdata_o = {30'h00000000, seq_run_permit_o, inhibit_q};
      else if (hit(paddr_i, `RIST_IRQS_OFF))
        prdata_o = {29'h00000000, irqs_q};
      else if (hit(paddr_i, `RIST_IRQM_OFF))
        prdata_o = {29'h00000000, irqm_q};
      else if (hit(paddr_i, `RIST_ENGY_OFF))
        prdata_o = {energy_meter_mwh_o, energy_meter_kwh_o};
      else if (hit(paddr_i, `RIST_POWY_OFF))
        prdata_o = powered_years_days_i;
    end
  end

endmodule

// File: dv/rist_seq_helper_properties.sv
`timescale 1ns/1ps
`include "rist_regs.vh"
module rist_seq_chk #(
  parameter BOTH_CYC = `RIST_BOTH_CYC
) (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire psel_i, // APB select
  input wire penable_i, // APB enable
  input wire pwrite_i, // APB direction
  input wire [11:0] paddr_i, // APB address
  input wire pslverr_o, // APB error
  input wire stop_key_i, // Stop key
  input wire run_key_i, // Run key
  input wire run_fwd_i, // Forward
  input wire run_rev_i, // Reverse
  input wire tripped_i, // Tripped
  input wire hardware_enable_i, // Enable pin
  input wire inverter_active_i, // Inverter on
  input wire seq_run_permit_o, // Run permit
  input wire trip_reset_o, // Trip reset
  input wire drive_enabled_o, // Drive enabled
  input wire run_hours_en_o, // Hours advance
  input wire energy_meter_clear_o, // Meter clear
  input wire [15:0] energy_meter_mwh_o, // MWh
  input wire [15:0] energy_meter_kwh_o, // kWh
  input wire filter_change_flag_o // Filter due
);
  int both_q;
  // Counts cycles with both run bits held, saturating
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      both_q <= 0;
    else if (!(run_fwd_i && run_rev_i))
      both_q <= 0;
    else if (both_q < BOTH_CYC + 8)
      both_q <= both_q + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_trip_withdraw: assert property (
    $rose(stop_key_i) ##0 (stop_key_i && tripped_i && !run_key_i)[*4]
    |-> ##[0:3] !seq_run_permit_o) else $error("run kept after stop");
  a_trip_reset: assert property (
    $rose(stop_key_i) ##0 (stop_key_i && tripped_i)[*4]
    |-> ##[0:3] trip_reset_o) else $error("no trip reset");
  a_trip_pulse: assert property (
    trip_reset_o |=> !trip_reset_o) else $error("trip reset too long");
  a_both_exit: assert property (
    both_q == BOTH_CYC + 8 && drive_enabled_o && !stop_key_i
    |-> seq_run_permit_o) else $error("both bits did not re-permit");
  a_drive_off: assert property (
    !hardware_enable_i[*5] |-> !drive_enabled_o) else $error("enable stuck");
  a_permit_off: assert property (
    !drive_enabled_o[*3] |-> !seq_run_permit_o) else $error("run while off");
  a_meter_held: assert property (
    energy_meter_clear_o && $past(energy_meter_clear_o)
    |-> energy_meter_mwh_o == 16'h0 && energy_meter_kwh_o == 16'h0)
    else $error("meter not held");
  a_hours_idle: assert property (
    !inverter_active_i[*5] |-> !run_hours_en_o) else $error("hours run");
  a_slverr_map: assert property (
    psel_i && penable_i && paddr_i[1:0] == 2'h0
    |-> pslverr_o == (paddr_i > `RIST_POWY_OFF)) else $error("bad pslverr");
  a_flag_sticky: assert property (
    filter_change_flag_o && !(psel_i && pwrite_i) &&
    !$past(psel_i && pwrite_i)
    |=> filter_change_flag_o) else $error("flag dropped");
  c_withdraw: cover property ($fell(seq_run_permit_o));
  c_trip: cover property (trip_reset_o);
  c_flag: cover property ($rose(filter_change_flag_o));
endmodule
bind rist_seq_helper rist_seq_chk #(.BOTH_CYC(BOTH_CYC)) chk_u (
  .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pslverr_o,
  .stop_key_i, .run_key_i, .run_fwd_i, .run_rev_i, .tripped_i,
  .hardware_enable_i, .inverter_active_i, .seq_run_permit_o,
  .trip_reset_o, .drive_enabled_o, .run_hours_en_o, .energy_meter_clear_o,
  .energy_meter_mwh_o, .energy_meter_kwh_o, .filter_change_flag_o
);

// File: dv/rist_keypad_model.sv
`timescale 1ns/1ps
module rist_keypad_model (
  input wire clk_i, // Clock
  input wire [8:0] cmd_i, // Requested key and run bits
  output logic [8:0] pins_o // Key and run bits to the block
);
  // fresh start pattern
  // Bits move only after an edge, like a real controller
  always @(posedge clk_i) begin
    pins_o <= cmd_i;
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "rist_regs.vh"
module testbench;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic trip_i = 0, uv_i = 0, kref_i = 0, inv_i = 0, hour_i = 0, hwen_i = 1;
  logic ce_i = 1;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd, em_i = 32'h00120345;
  logic [15:0] pkw_i = 16'h0004;
  logic [8:0] cmd = 0;
  logic er;
  wire [8:0] pins;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, den_o, emc_o, irq_o, frk_o;
  int checks = 0, fail_count = 0, cyc_n = 0;
  rist_keypad_model key_u (.clk_i, .cmd_i(cmd), .pins_o(pins));
  rist_seq_helper #(.BOTH_CYC(20)) dut_u (
    .clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i(4'hf), .pready_o, .prdata_o, .pslverr_o,
    .stop_key_i(pins[0]), .run_key_i(pins[1]), .run_fwd_i(pins[2]),
    .run_rev_i(pins[3]), .run_seq_i(pins[4]), .not_stop_i(pins[5]),
    .fwd_latched_i(pins[6]), .rev_latched_i(pins[7]),
    .seq_latched_i(pins[8]), .hardware_enable_i(hwen_i),
    .tripped_i(trip_i), .undervoltage_state_i(uv_i), .keypad_ref_i(kref_i),
    .inverter_active_i(inv_i), .run_hour_tick_i(hour_i),
    .energy_meter_mwh_i(em_i[31:16]), .energy_meter_kwh_i(em_i[15:0]),
    .power_kw_i(pkw_i), .powered_years_days_i(em_i),
    .seq_run_permit_o(), .trip_reset_o(), .drive_enabled_o(den_o),
    .run_hours_en_o(), .energy_meter_clear_o(emc_o),
    .fwd_rev_key_enable_o(frk_o), .energy_meter_mwh_o(),
    .energy_meter_kwh_o(),
    .running_cost_o(), .filter_change_flag_o(), .irq_o);
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    cyc(1);
    penable_i <= 1'b1;
    cyc(1);
    while (pready_o !== 1'b1) cyc(1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    cyc(1);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pins_to(input logic [8:0] v);
    cmd <= v;
    cyc(8);
  endtask
  task automatic press;
    cmd[0] <= 1'b1;
    cyc(8);
    cmd[0] <= 1'b0;
    cyc(8);
  endtask
  task automatic hour;
    hour_i <= 1'b1;
    cyc(6);
    hour_i <= 1'b0;
    cyc(6);
  endtask
  // Main sequence
  initial begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(1);
    rc(`RIST_CTRL_OFF, 32'h4);
    rc(`RIST_PRICE_OFF, 32'h0);
    rc(`RIST_FINT_OFF, 32'h0);
    rc(`RIST_FLAG_OFF, 32'h0);
    xf(1'b0, 12'h02c, 32'h0);
    chk(er, 32'h1);
    xf(1'b1, `RIST_CTRL_OFF, 32'h0);
    cyc(2);
    chk(den_o, 32'h0);
    xf(1'b1, `RIST_CTRL_OFF, 32'h4);
    hwen_i <= 1'b0;
    cyc(6);
    chk(den_o, 32'h0);
    hwen_i <= 1'b1;
    cyc(6);
    chk(den_o, 32'h1);
    xf(1'b1, `RIST_PRICE_OFF, 32'h1b58);
    rc(`RIST_PRICE_OFF, 32'h1770);
    xf(1'b1, `RIST_PRICE_OFF, 32'h19);
    rc(`RIST_COST_OFF, 32'h64);
    ce_i <= 1'b0;
    xf(1'b1, `RIST_PRICE_OFF, 32'h5);
    ce_i <= 1'b1;
    rc(`RIST_PRICE_OFF, 32'h19);
    rc(`RIST_ENGY_OFF, 32'h00120345);
    rc(`RIST_POWY_OFF, 32'h00120345);
    xf(1'b1, `RIST_CTRL_OFF, 32'he);
    rc(`RIST_ENGY_OFF, 32'h0);
    chk(emc_o, 32'h1);
    chk(frk_o, 32'h1);
    xf(1'b1, `RIST_FINT_OFF, 32'h2);
    xf(1'b1, `RIST_FLAG_OFF, 32'h1);
    xf(1'b1, `RIST_FLAG_OFF, 32'h0);
    rc(`RIST_FLEFT_OFF, 32'h2);
    hour();
    rc(`RIST_FLEFT_OFF, 32'h2);
    inv_i <= 1'b1;
    hour();
    hour();
    rc(`RIST_FLEFT_OFF, 32'h0);
    rc(`RIST_FLAG_OFF, 32'h1);
    xf(1'b1, `RIST_IRQM_OFF, 32'h7);
    chk(irq_o, 32'h1);
    xf(1'b1, `RIST_FLAG_OFF, 32'h0);
    xf(1'b1, `RIST_IRQS_OFF, 32'h1);
    chk(irq_o, 32'h0);
    inv_i <= 1'b0;
    xf(1'b1, `RIST_FINT_OFF, 32'h9c40);
    rc(`RIST_FINT_OFF, 32'h7530);
    xf(1'b1, `RIST_FINT_OFF, 32'h0);
    xf(1'b1, `RIST_FLAG_OFF, 32'h1);
    xf(1'b1, `RIST_FLAG_OFF, 32'h0);
    rc(`RIST_FLEFT_OFF, 32'h0);
    xf(1'b1, `RIST_CTRL_OFF, 32'h5);
    pins_to(9'h004);
    press();
    rc(`RIST_STAT_OFF, 32'h1);
    rc(`RIST_IRQS_OFF, 32'h2);
    pins_to(9'h000);
    rc(`RIST_STAT_OFF, 32'h2);
    pins_to(9'h004);
    press();
    uv_i <= 1'b1;
    cyc(8);
    rc(`RIST_STAT_OFF, 32'h2);
    uv_i <= 1'b0;
    xf(1'b1, `RIST_CTRL_OFF, 32'h4);
    press();
    rc(`RIST_STAT_OFF, 32'h2);
    xf(1'b1, `RIST_IRQS_OFF, 32'h7);
    trip_i <= 1'b1;
    kref_i <= 1'b1;
    pins_to(9'h006);
    press();
    rc(`RIST_STAT_OFF, 32'h2);
    rc(`RIST_IRQS_OFF, 32'h4);
    kref_i <= 1'b0;
    press();
    rc(`RIST_STAT_OFF, 32'h1);
    rc(`RIST_IRQS_OFF, 32'h6);
    pins_to(9'h004);
    press();
    rc(`RIST_STAT_OFF, 32'h1);
    trip_i <= 1'b0;
    pins_to(9'h000);
    xf(1'b1, `RIST_CTRL_OFF, 32'h15);
    pins_to(9'h064);
    press();
    rc(`RIST_STAT_OFF, 32'h1);
    pins_to(9'h060);
    rc(`RIST_STAT_OFF, 32'h1);
    pins_to(9'h040);
    rc(`RIST_STAT_OFF, 32'h2);
    pins_to(9'h064);
    press();
    pins_to(9'h0ec);
    pins_to(9'h0e4);
    rc(`RIST_STAT_OFF, 32'h1);
    pins_to(9'h0ec);
    cyc(24);
    rc(`RIST_STAT_OFF, 32'h2);
    give_verdict();
  end
endmodule
